// ==== rtl/hpx_expander_master.sv ====
// SMBus master that mirrors slot hot-plug signals into three I/O expanders.
// Assumes open-drain SCL/SDA resolved outside and inputs synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module hpx_expander_master #(
  parameter int unsigned UPDATE_CYCLES = hpx_pkg::UPDATE_PERIOD_CYC,
  parameter int unsigned QUARTER       = hpx_pkg::QUARTER_CYC
) (
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [7:0]                             paddr,
  input  wire logic [31:0]                            pwdata,
  output var  logic [31:0]                            prdata,
  output var  logic                                   pready,
  output var  logic                                   pslverr,
  input  wire logic                                   cfg_load_busy,
  input  wire logic [hpx_pkg::NUM_EXP-1:0]            exp_int_n,
  input  wire hpx_pkg::hpx_slot_out_s [hpx_pkg::NUM_SLOT-1:0] slot_out,
  output wire hpx_pkg::hpx_slot_in_s  [hpx_pkg::NUM_SLOT-1:0] slot_in,
  output wire logic [6:0]                             slot_power_good_n,
  input  wire logic                                   scl_i,
  output var  logic                                   scl_o,
  output var  logic                                   scl_oe,
  input  wire logic                                   sda_i,
  output var  logic                                   sda_o,
  output var  logic                                   sda_oe
);
  import hpx_pkg::*;

  localparam int unsigned HOLD_W = $clog2(UPDATE_CYCLES + 1);
  localparam int unsigned QW     = $clog2(QUARTER + 1);

  logic                ctrl_en_r;
  logic [6:0]          addr_r    [NUM_EXP];
  logic [15:0]         in_r      [NUM_EXP];
  logic [15:0]         wr_r      [NUM_EXP];
  logic [HOLD_W-1:0]   hold_r    [NUM_EXP];
  hpx_stage_e          stage_r   [NUM_EXP];
  logic                nack_r;
  logic                pready_r;
  logic [31:0]         prdata_r;
  logic                pslverr_r;
  hpx_bus_e            st_r;
  logic [QW-1:0]       qcnt_r;
  logic [1:0]          q_r;
  logic [3:0]          bit_r;
  logic [2:0]          step_r;
  logic [7:0]          sh_r;
  logic [7:0]          rd_lo_r;
  logic                err_r;
  logic [1:0]          job_exp_r;
  logic                job_rd_r;
  logic [7:0]          job_cmd_r;
  logic [15:0]         job_data_r;
  logic [1:0]          rr_r;
  logic                scl_oe_r;
  logic                sda_oe_r;
  logic                line_o_r;

  // Output image of one expander from the slot outputs
  function automatic logic [15:0] out_image(input logic [1:0] e,
                                            input hpx_slot_out_s [NUM_SLOT-1:0] so);
    unique case (e)
      2'd0:    out_image = {so[2], IN_PAD, so[0], IN_PAD};
      2'd1:    out_image = {so[3], IN_PAD, so[1], IN_PAD};
      default: out_image = {BYTE_PAD, so[4], IN_PAD};
    endcase
  endfunction

  function automatic logic [7:0] tx_of(input logic [2:0] s, input logic rd,
                                       input logic [6:0] a, input logic [7:0] c,
                                       input logic [15:0] d);
    unique case (s)
      3'd0:    tx_of = {a, 1'b0};
      3'd1:    tx_of = c;
      3'd2:    tx_of = rd ? {a, 1'b1} : d[7:0];
      default: tx_of = d[15:8];
    endcase
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == CTRL_OFS) || (a == ADDR_OFS) || (a == STAT_OFS) ||
               (a == DATA0_OFS) || (a == DATA1_OFS) || (a == DATA2_OFS);
  endfunction

  // Slot and power-good inputs straight from the read registers
  assign slot_in[0]        = in_r[0][3:0];
  assign slot_in[2]        = in_r[0][11:8];
  assign slot_in[1]        = in_r[1][3:0];
  assign slot_in[3]        = in_r[1][11:8];
  assign slot_in[4]        = in_r[2][3:0];
  assign slot_power_good_n = in_r[2][15:9];

  // APB slave, one wait state
  logic apb_acc;
  logic apb_wr;
  assign apb_acc = psel && penable && !pready_r;
  assign apb_wr  = psel && penable && pready_r && pwrite && addr_hit(paddr);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFS:  rd_mux[CTRL_EN_BIT] = ctrl_en_r;
      ADDR_OFS:  rd_mux = {9'h000, addr_r[2], 1'b0, addr_r[1], 1'b0, addr_r[0]};
      STAT_OFS:  rd_mux = {27'h0000000, nack_r, st_r != ST_IDLE,
                           stage_r[2] == STG_DONE, stage_r[1] == STG_DONE,
                           stage_r[0] == STG_DONE};
      DATA0_OFS: rd_mux = {wr_r[0], in_r[0]};
      DATA1_OFS: rd_mux = {wr_r[1], in_r[1]};
      DATA2_OFS: rd_mux = {wr_r[2], in_r[2]};
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_acc;
      prdata_r  <= (apb_acc && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_r <= apb_acc && !addr_hit(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r <= CTRL_EN_RST;
      addr_r[0] <= ADDR0_RST;
      addr_r[1] <= ADDR1_RST;
      addr_r[2] <= ADDR2_RST;
    end else if (apb_wr) begin
      if (paddr == CTRL_OFS) begin
        ctrl_en_r <= pwdata[CTRL_EN_BIT];
      end
      if (paddr == ADDR_OFS) begin
        addr_r[0] <= pwdata[6:0];
        addr_r[1] <= pwdata[14:8];
        addr_r[2] <= pwdata[22:16];
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Service requests and round-robin pick
  logic        run_ok;
  logic [2:0]  need;
  logic [1:0]  pick;
  logic        pick_vld;
  logic [1:0]  idx;
  assign run_ok = ctrl_en_r && !cfg_load_busy;

  always_comb begin
    need = 3'b000;
    for (int e = 0; e < NUM_EXP; e++) begin
      need[e] = run_ok && (hold_r[e] == '0) &&
                ((stage_r[e] != STG_DONE) ||
                 (out_image(2'(e), slot_out) != wr_r[e]) ||
                 !exp_int_n[e]);
    end
  end

  always_comb begin
    pick     = 2'd0;
    pick_vld = 1'b0;
    idx      = 2'd0;
    for (int k = 0; k < NUM_EXP; k++) begin
      idx = 2'((32'(rr_r) + 32'(k)) % NUM_EXP);
      if (!pick_vld && need[idx]) begin
        pick     = idx;
        pick_vld = 1'b1;
      end
    end
  end

  // Job contents chosen at launch
  logic        launch;
  logic        l_rd;
  logic [7:0]  l_cmd;
  logic [15:0] l_data;
  assign launch = (st_r == ST_IDLE) && pick_vld;

  always_comb begin
    l_rd   = 1'b0;
    l_cmd  = XREG_OUTPUT;
    l_data = out_image(pick, slot_out);
    unique case (stage_r[pick])
      STG_OUT: l_cmd = XREG_OUTPUT;
      STG_POL: begin
        l_cmd  = XREG_POLARITY;
        l_data = POL_VAL;
      end
      STG_DIR: begin
        l_cmd  = XREG_DIR;
        l_data = (pick == 2'd2) ? DIR_EXP2 : DIR_HP;
      end
      STG_READ: begin
        l_cmd = XREG_INPUT;
        l_rd  = 1'b1;
      end
      default: begin
        l_rd  = (l_data == wr_r[pick]);
        l_cmd = l_rd ? XREG_INPUT : XREG_OUTPUT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      job_exp_r  <= 2'd0;
      job_rd_r   <= 1'b0;
      job_cmd_r  <= XREG_OUTPUT;
      job_data_r <= WR_RST;
      rr_r       <= 2'd0;
    end else if (launch) begin
      job_exp_r  <= pick;
      job_rd_r   <= l_rd;
      job_cmd_r  <= l_cmd;
      job_data_r <= l_data;
      rr_r       <= (pick == 2'd2) ? 2'd0 : pick + 2'd1;
    end
  end

  // Quarter-bit enable
  logic qtick;
  logic adv;
  assign qtick = (qcnt_r == QW'(QUARTER - 1));
  assign adv   = qtick && !(q_r == 2'd1 && !scl_i);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_r <= '0;
    end else if (st_r == ST_IDLE || qtick) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + QW'(1);
    end
  end

  // Bit and byte sequencing
  logic rd_byte;
  logic last_step;
  logic done;
  assign rd_byte   = job_rd_r && (step_r >= 3'd3);
  assign last_step = job_rd_r ? (step_r == 3'd4) : (step_r == 3'd3);
  assign done      = (st_r == ST_STOP) && adv && (q_r == 2'd3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= ST_IDLE;
      q_r     <= 2'd0;
      bit_r   <= 4'd0;
      step_r  <= 3'd0;
      sh_r    <= 8'h00;
      rd_lo_r <= 8'h00;
      err_r   <= 1'b0;
    end else if (launch) begin
      st_r   <= ST_START;
      q_r    <= 2'd0;
      step_r <= 3'd0;
      err_r  <= 1'b0;
    end else if (adv) begin
      q_r <= q_r + 2'd1;
      unique case (st_r)
        ST_IDLE: q_r <= 2'd0;
        ST_START: if (q_r == 2'd3) begin
          st_r  <= ST_BYTE;
          bit_r <= 4'd0;
          sh_r  <= tx_of(step_r, job_rd_r, addr_r[job_exp_r], job_cmd_r, job_data_r);
        end
        ST_BYTE: begin
          if (q_r == 2'd2) begin
            if (bit_r < 4'd8 && rd_byte) begin
              sh_r <= {sh_r[6:0], sda_i};
            end
            if (bit_r == 4'd8 && !rd_byte && sda_i) begin
              err_r <= 1'b1;
            end
          end
          if (q_r == 2'd3) begin
            if (bit_r < 4'd8) begin
              bit_r <= bit_r + 4'd1;
              if (!rd_byte) begin
                sh_r <= {sh_r[6:0], 1'b0};
              end
            end else if (err_r || last_step) begin
              st_r <= ST_STOP;
            end else if (job_rd_r && step_r == 3'd1) begin
              st_r   <= ST_START;
              step_r <= 3'd2;
            end else begin
              if (step_r == 3'd3) begin
                rd_lo_r <= sh_r;
              end
              step_r <= step_r + 3'd1;
              bit_r  <= 4'd0;
              sh_r   <= tx_of(step_r + 3'd1, job_rd_r, addr_r[job_exp_r],
                              job_cmd_r, job_data_r);
            end
          end
        end
        ST_STOP: if (q_r == 2'd3) begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Line levels; low means drive
  logic scl_lvl;
  logic sda_lvl;
  always_comb begin
    scl_lvl = 1'b1;
    sda_lvl = 1'b1;
    unique case (st_r)
      ST_IDLE: begin
        scl_lvl = 1'b1;
        sda_lvl = 1'b1;
      end
      ST_START: begin
        scl_lvl = (q_r == 2'd1) || (q_r == 2'd2);
        sda_lvl = (q_r < 2'd2);
      end
      ST_BYTE: begin
        scl_lvl = (q_r == 2'd1) || (q_r == 2'd2);
        if (bit_r == 4'd8) begin
          sda_lvl = rd_byte ? (step_r == 3'd4) : 1'b1;
        end else begin
          sda_lvl = rd_byte ? 1'b1 : sh_r[7];
        end
      end
      ST_STOP: begin
        scl_lvl = (q_r != 2'd0);
        sda_lvl = (q_r >= 2'd2);
      end
    endcase
  end

  // Reset releases both lines, so no transfer completes on reset entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      line_o_r <= 1'b0;
    end else begin
      scl_oe_r <= !scl_lvl;
      sda_oe_r <= !sda_lvl;
      line_o_r <= 1'b0;
    end
  end

  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign scl_o  = line_o_r;
  assign sda_o  = line_o_r;

  // Per-expander state, images and update holdoff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int e = 0; e < NUM_EXP; e++) begin
        stage_r[e] <= STG_OUT;
        in_r[e]    <= IN_RST;
        wr_r[e]    <= WR_RST;
        hold_r[e]  <= '0;
      end
    end else begin
      for (int e = 0; e < NUM_EXP; e++) begin
        if (hold_r[e] != '0) begin
          hold_r[e] <= hold_r[e] - HOLD_W'(1);
        end
      end
      if (done) begin
        if (!err_r) begin
          if (job_rd_r) begin
            in_r[job_exp_r] <= {sh_r, rd_lo_r};
          end else if (job_cmd_r == XREG_OUTPUT) begin
            wr_r[job_exp_r] <= job_data_r;
          end
          unique case (stage_r[job_exp_r])
            STG_OUT:  stage_r[job_exp_r] <= STG_POL;
            STG_POL:  stage_r[job_exp_r] <= STG_DIR;
            STG_DIR:  stage_r[job_exp_r] <= STG_READ;
            default:  stage_r[job_exp_r] <= STG_DONE;
          endcase
        end
        if (err_r || stage_r[job_exp_r] >= STG_READ) begin
          hold_r[job_exp_r] <= HOLD_W'(UPDATE_CYCLES);
        end
      end
    end
  end

  // Sticky no-acknowledge flag; a new error beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nack_r <= 1'b0;
    end else if (done && err_r) begin
      nack_r <= 1'b1;
    end else if (apb_wr && paddr == STAT_OFS && pwdata[STAT_NACK_BIT]) begin
      nack_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== include/hpx_pkg.sv ====
// Constants, types and register map of the hot-plug I/O expander master.
// Assumes a 50 MHz core clock and 16-bit SMBus I/O expanders as slaves.
package hpx_pkg;
  localparam int unsigned CLK_FREQ_KHZ      = 50000;
  localparam int unsigned UPDATE_PERIOD_MS  = 40;
  localparam int unsigned UPDATE_PERIOD_CYC = UPDATE_PERIOD_MS * CLK_FREQ_KHZ;
  localparam int unsigned SCL_FREQ_KHZ      = 100;
  localparam int unsigned QUARTER_CYC       = CLK_FREQ_KHZ / (4 * SCL_FREQ_KHZ);
  localparam int unsigned NUM_EXP           = 3;
  localparam int unsigned NUM_SLOT          = 5;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] ADDR_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS  = 8'h08;
  localparam logic [7:0] DATA0_OFS = 8'h0c;
  localparam logic [7:0] DATA1_OFS = 8'h10;
  localparam logic [7:0] DATA2_OFS = 8'h14;

  // Register fields and reset values
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned STAT_BUSY_BIT = 3;
  localparam int unsigned STAT_NACK_BIT = 4;
  localparam logic        CTRL_EN_RST   = 1'b0;
  localparam logic [6:0]  ADDR0_RST     = 7'h20;
  localparam logic [6:0]  ADDR1_RST     = 7'h21;
  localparam logic [6:0]  ADDR2_RST     = 7'h22;

  // Expander command bytes and fixed values
  localparam logic [7:0]  XREG_INPUT    = 8'h00;
  localparam logic [7:0]  XREG_OUTPUT   = 8'h02;
  localparam logic [7:0]  XREG_POLARITY = 8'h04;
  localparam logic [7:0]  XREG_DIR      = 8'h06;
  localparam logic [15:0] DIR_HP        = 16'h0f0f;
  localparam logic [15:0] DIR_EXP2      = 16'hff0f;
  localparam logic [15:0] POL_VAL       = 16'h0000;
  localparam logic [15:0] IN_RST        = 16'hffff;
  localparam logic [15:0] WR_RST        = 16'h0000;
  localparam logic [3:0]  IN_PAD        = 4'hf;
  localparam logic [7:0]  BYTE_PAD      = 8'hff;

  typedef struct packed {
    logic interlock;
    logic power_enable;
    logic power_indicator;
    logic attn_indicator;
  } hpx_slot_out_s;

  typedef struct packed {
    logic latch_open_n;
    logic power_fault_n;
    logic presence_n;
    logic attn_button_n;
  } hpx_slot_in_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BYTE  = 2'b10,
    ST_STOP  = 2'b11
  } hpx_bus_e;

  typedef enum logic [2:0] {
    STG_OUT  = 3'b000,
    STG_POL  = 3'b001,
    STG_DIR  = 3'b010,
    STG_READ = 3'b011,
    STG_DONE = 3'b100
  } hpx_stage_e;
endpackage

// ==== tb/hpx_checker.sv ====
// Port checks for the hot-plug expander master.
// Bound into hpx_expander_master; one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module hpx_checker #(
  parameter int unsigned QUARTER       = 4,
  parameter int unsigned UPDATE_CYCLES = hpx_pkg::UPDATE_PERIOD_CYC
) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         cfg_load_busy,
  input wire logic [hpx_pkg::NUM_EXP-1:0]  exp_int_n,
  input wire logic                         scl_o,
  input wire logic                         scl_oe,
  input wire logic                         sda_o,
  input wire logic                         sda_oe
);
  import hpx_pkg::*;
  localparam int unsigned IRQ_LIMIT = UPDATE_CYCLES + 1000 * QUARTER;
  logic [15:0] load_idle_r;
  logic [31:0] irq_wait_r;
  logic        int_all_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Idle bus cycles while loading runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_idle_r <= 16'h0;
    end else if (cfg_load_busy && !scl_oe && !sda_oe) begin
      load_idle_r <= load_idle_r + {15'h0, load_idle_r != 16'hffff};
    end else begin
      load_idle_r <= 16'h0;
    end
  end
  // Cycles a fresh interrupt has waited for its read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_all_r  <= 1'b0;
      irq_wait_r <= 32'h0;
    end else begin
      int_all_r <= &exp_int_n;
      if (&exp_int_n) begin
        irq_wait_r <= 32'h0;
      end else if (irq_wait_r != 32'h0 || (int_all_r && !cfg_load_busy)) begin
        irq_wait_r <= irq_wait_r + {31'h0, irq_wait_r != 32'hffffffff};
      end
    end
  end
  ready_timing_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not on second cycle after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr without pready or with data");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  load_quiet_a: assert property (
    cfg_load_busy && load_idle_r >= 4 * QUARTER + 4 |=> !scl_oe && !sda_oe)
    else $error("frame started while loading");
  scl_high_a: assert property ($fell(scl_oe) |-> !scl_oe [*8])
    else $error("clock high phase too short");
  irq_service_a: assert property (
    irq_wait_r <= IRQ_LIMIT)
    else $error("interrupt not serviced by a read");
  cover property (pslverr);
  cover property ($fell(&exp_int_n));
  cover property ($rose(sda_oe) && !scl_oe);
endmodule

bind hpx_expander_master hpx_checker #(.QUARTER(QUARTER), .UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cfg_load_busy(cfg_load_busy), .exp_int_n(exp_int_n), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// ==== tb/hpx_exp_model.sv ====
// Behavioural model of three 16-bit SMBus I/O expanders at 0x20-0x22.
// Assumes wired-AND lines with pull-ups resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module hpx_exp_model (
  input  wire logic             scl,
  input  wire logic             sda,
  input  wire logic [2:0][15:0] pins,
  output var  logic             sda_pull,
  output var  logic [2:0]       int_n
);
  logic [2:0][15:0] outr, polr, dirr, last_rd, seq;
  logic [15:0]      rv;
  logic [7:0]       sh, tx;
  logic [2:0]       ptr;
  logic [1:0]       sel;
  logic             mine, rd;
  int               bitn, byten, nstart;
  time              t_end [3];
  time              gap [3];
  // Power-up state; polarity left stale on purpose
  initial begin
    {outr, polr, dirr, last_rd} = '1;
    seq = '0;
    sda_pull = 1'b0;
    mine = 1'b0;
    {bitn, byten, nstart} = '0;
    t_end = '{default: 0};
  end
  // Interrupt while an input differs from the last read
  always_comb begin
    for (int i = 0; i < 3; i++) int_n[i] = ~|((pins[i] ^ last_rd[i]) & dirr[i]);
  end
  // Start or repeated start
  always @(negedge sda) begin
    if (scl) begin
      bitn = 0;
      byten = 0;
      mine = 1'b0;
      nstart++;
    end
  end
  // Stop ends a transaction
  always @(posedge sda) begin
    if (scl && mine) t_end[sel] = $time;
  end
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    bitn++;
  end
  always @(negedge scl) begin
    if (bitn == 8) begin
      sda_pull = 1'b0;
      if (byten == 0) begin
        mine = sh[7:3] == 5'b01000 && sh[2:1] != 2'b11;
        sel = sh[2:1];
        rd = sh[0];
        if (mine && !rd) gap[sel] = $time - t_end[sel];
        sda_pull = mine;
      end else if (mine && !rd) begin
        if (byten == 1) begin
          ptr = sh[2:0];
          seq[sel] = {seq[sel][11:0], sh[3:0]};
        end else if (ptr[2:1] == 2'd1) outr[sel][ptr[0]*8 +: 8] = sh;
        else if (ptr[2:1] == 2'd2) polr[sel][ptr[0]*8 +: 8] = sh;
        else if (ptr[2:1] == 2'd3) dirr[sel][ptr[0]*8 +: 8] = sh;
        if (byten > 1) ptr[0] = ~ptr[0];
        sda_pull = 1'b1;
      end
    end else if (bitn == 9) begin
      bitn = 0;
      byten++;
      if (mine && rd && byten == 1) begin
        rv = (outr[sel] & ~dirr[sel]) | (pins[sel] & dirr[sel]);
        last_rd[sel] = rv;
        tx = rv[7:0];
      end else if (mine && rd && byten == 2 && !sh[0]) tx = rv[15:8];
      else tx = 8'hff;
      sda_pull = ~tx[7];
    end else if (mine && rd && byten > 0) sda_pull = ~tx[7 - bitn];
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the hot-plug expander master.
// APB and slot signals from here; expander model answers on SMBus.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hpx_pkg::*;
  localparam int unsigned UPD = 200;
  localparam int unsigned QTR = 4;
  logic                         pclk;
  logic                         presetn;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [7:0]                   paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         busy;
  logic [2:0]                   int_n;
  hpx_slot_out_s [NUM_SLOT-1:0] slot_out;
  hpx_slot_in_s  [NUM_SLOT-1:0] slot_in;
  logic [6:0]                   pgood_n;
  logic [2:0][15:0]             pins;
  logic                         scl_oe;
  logic                         sda_oe;
  logic                         sda_pull;
  wire logic                    scl_w;
  wire logic                    sda_w;
  logic [31:0]                  rdat;
  logic                         rerr;
  logic [15:0]                  snap;
  logic [15:0]                  d;
  int                           fail_count;
  int                           check_count;
  assign scl_w = ~scl_oe;
  assign sda_w = ~(sda_oe | sda_pull);
  hpx_expander_master #(.UPDATE_CYCLES(UPD), .QUARTER(QTR)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_load_busy(busy), .exp_int_n(int_n), .slot_out(slot_out), .slot_in(slot_in),
    .slot_power_good_n(pgood_n), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
  hpx_exp_model u_exp (
    .scl(scl_w), .sda(sda_w), .pins(pins), .sda_pull(sda_pull), .int_n(int_n));
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  function automatic logic [15:0] img(input int i);
    if (i == 0) img = {slot_out[2], 4'hf, slot_out[0], 4'hf};
    else if (i == 1) img = {slot_out[3], 4'hf, slot_out[1], 4'hf};
    else img = {8'hff, slot_out[4], 4'hf};
  endfunction
  function automatic logic [19:0] sin();
    sin = {pins[2][3:0], pins[1][11:8], pins[0][11:8], pins[1][3:0], pins[0][3:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk({31'h0, rerr}, {31'h0, err});
  endtask
  task automatic quiet;
    int q;
    q = 0;
    while (q < UPD + 40) begin
      @(posedge pclk);
      q = (scl_oe || sda_oe) ? 0 : q + 1;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    fail_count++;
    $display("[ERR] %0t timeout", $time);
    report_and_stop;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    busy = 1'b1;
    slot_out = 20'h12345;
    pins = {16'h6bfa, 16'hfcf5, 16'hf9f6};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CTRL_OFS, 32'h0, 1'b0);
    rdc(ADDR_OFS, 32'h00222120, 1'b0);
    rdc(STAT_OFS, 32'h0, 1'b0);
    rdc(8'h18, 32'h0, 1'b1);
    chk({5'h0, slot_in, pgood_n}, 32'h07ffffff);
    apb(1'b1, CTRL_OFS, 32'h1);
    rdc(CTRL_OFS, 32'h1, 1'b0);
    repeat (40) @(posedge pclk);
    slot_out <= 20'h9abcd;
    repeat (40) @(posedge pclk);
    chk(u_exp.nstart, 32'h0);
    slot_out <= 20'h5a3c6;
    busy <= 1'b0;
    quiet;
    rdc(STAT_OFS, 32'h7, 1'b0);
    for (int i = 0; i < 3; i++) begin
      d = (i == 2) ? 16'hff0f : 16'h0f0f;
      chk({16'h0, u_exp.outr[i]}, {16'h0, img(i)});
      chk({16'h0, u_exp.dirr[i]}, {16'h0, d});
      chk({16'h0, u_exp.polr[i]}, 32'h0);
      chk({16'h0, u_exp.seq[i]}, 32'h2460);
      rdc(DATA0_OFS + 8'(4 * i), {img(i), (img(i) & ~d) | (pins[i] & d)}, 1'b0);
    end
    chk({12'h0, slot_in}, {12'h0, sin()});
    chk({25'h0, pgood_n}, {25'h0, pins[2][15:9]});
    @(posedge pclk);
    slot_out[2] <= 4'h6;
    while (u_exp.outr[0][15:12] !== 4'h6) @(posedge pclk);
    slot_out[2] <= 4'h9;
    quiet;
    chk({16'h0, u_exp.outr[0]}, {16'h0, img(0)});
    chk({31'h0, u_exp.gap[0] >= UPD * 20}, 32'h1);
    @(posedge pclk);
    pins[1][10] <= 1'b0;
    slot_out[4] <= 4'h4;
    quiet;
    chk({12'h0, slot_in}, {12'h0, sin()});
    chk({16'h0, u_exp.outr[2]}, 32'h0000ff4f);
    apb(1'b1, ADDR_OFS, 32'h00262120);
    rdc(ADDR_OFS, 32'h00262120, 1'b0);
    slot_out[4] <= 4'h7;
    do begin
      apb(1'b0, STAT_OFS, 32'h0);
    end while (rdat[STAT_NACK_BIT] !== 1'b1);
    chk(rdat, 32'h17);
    apb(1'b1, ADDR_OFS, 32'h00222120);
    apb(1'b1, STAT_OFS, 32'h10);
    quiet;
    rdc(STAT_OFS, 32'h7, 1'b0);
    chk({16'h0, u_exp.outr[2]}, {16'h0, img(2)});
    snap = u_exp.outr[0];
    @(posedge pclk);
    slot_out[0] <= 4'hf;
    while (sda_oe !== 1'b1) @(posedge pclk);
    repeat (6) @(posedge pclk);
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    quiet;
    chk({16'h0, u_exp.outr[0]}, {16'h0, snap});
    rdc(CTRL_OFS, 32'h0, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
